// ---- dcr_defs.vh ----
`ifndef DCR_DEFS_VH
`define DCR_DEFS_VH

// Register addresses of the per-channel register set.
`define DCR_ADDR_FUNCTION 8'h03
`define DCR_ADDR_FREQ 8'h04
`define DCR_ADDR_PHASE 8'h05
`define DCR_ADDR_AMP 8'h06
`define DCR_ADDR_SWEEP_RATE 8'h07
`define DCR_ADDR_RISE_DELTA 8'h08
`define DCR_ADDR_FALL_DELTA 8'h09

// Register widths.
`define DCR_FUNCTION_W 24
`define DCR_PHASE_REG_W 16
`define DCR_AMP_W 24
`define DCR_SWEEP_RATE_W 16
`define DCR_WORD_W 32

// Channel function fields.
`define DCR_CF_SINE 0
`define DCR_CF_PHASE_CLR 1
`define DCR_CF_PHASE_AUTO 2
`define DCR_CF_SWEEP_CLR 3
`define DCR_CF_SWEEP_AUTO 4
`define DCR_CF_MATCH_DELAY 5
`define DCR_CF_DAC_PD 6
`define DCR_CF_CORE_PD 7
`define DCR_CF_LSB_HI 9
`define DCR_CF_LSB_LO 8
`define DCR_CF_RATE_LOAD 13
`define DCR_CF_SWEEP_EN 14
`define DCR_CF_NO_DWELL 15
`define DCR_CF_ALIGN_HI 18
`define DCR_CF_ALIGN_LO 16
`define DCR_CF_MOD_HI 23
`define DCR_CF_MOD_LO 22

// Phase offset fields.
`define DCR_PH_HI 13
`define DCR_PH_W 14

// Amplitude control fields.
`define DCR_AC_SCALE_HI 9
`define DCR_AC_SCALE_W 10
`define DCR_AC_RATE_LOAD 10
`define DCR_AC_AUTO 11
`define DCR_AC_MULT_EN 12
`define DCR_AC_STEP_HI 15
`define DCR_AC_STEP_LO 14
`define DCR_AC_RATE_HI 23
`define DCR_AC_RATE_LO 16
`define DCR_AC_RATE_W 8

// Reset values.
`define DCR_FUNCTION_RESET 24'h000000
`define DCR_WORD_RESET 32'h00000000
`define DCR_PHASE_RESET 16'h0000
`define DCR_AMP_RESET 24'h000000
`define DCR_SWEEP_RATE_RESET 16'h0000

// Ramp-rate timers time out at this count.
`define DCR_TIMER_END_SWEEP 16'h0001
`define DCR_TIMER_END_AMP 8'h01

`endif

// ---- dcr_channel_regs.v ----
// Behaviour
// R1 - Second-register auto-clear zeroes all sweep accumulators on update
// R2 - Function bit 0 picks cosine or sine
// R3 - Function bit 1 holds phase accumulator cleared
// R4 - Function bit 2 zeroes phase accumulator on update
// R5 - Function bit 3 holds sweep accumulator cleared
// R6 - Function bit 4 zeroes sweep accumulator on update
// R7 - Function bit 5 turns on matched pipeline delay
// R8 - Function bit 6 powers the converter down
// R9 - Function bit 7 powers the digital core down
// R10 - Software keeps bit 10 zero; LSB field resets 00
// R11 - Sweep timer reloads at one, optionally on update
// R12 - Function bit 14 enables linear frequency sweep
// R13 - No-dwell bit ignored while sweep disabled
// R14 - Modulation type and data-align fields per channel
// R15 - Separate frequency tuning word per channel
// R16 - Phase offset is 14 bits, top two inactive
// R17 - Amplitude register holds scale, step, ramp rate
// R18 - Amplitude timer reloads on timeout, or on update or profile change if bit 10 set
// R19 - Bit 11 picks auto ramp only with multiplier
// R20 - Bit 12 zero bypasses and stops the multiplier
// R21 - Sweep rate register holds rising rate
// R22 - Per-channel 32-bit rising delta word
// R23 - Per-channel 32-bit falling delta word
// R24 - Channel enables choose which channels take writes
// R25 - Writes buffered, moved to active on update
`timescale 1ns/10ps
`default_nettype none
`include "dcr_defs.vh"

module dcr_channel_regs #(
  parameter CHANNELS = 4
) (
  input wire CLOCK,
  input wire RST,
  input wire WRITE_STROBE,
  input wire [7:0] WRITE_ADDR,
  input wire [31:0] WRITE_DATA,
  input wire [CHANNELS-1:0] CHANNEL_ENABLE,
  input wire [7:0] READ_ADDR,
  input wire [1:0] READ_CHANNEL,
  output reg [31:0] READ_DATA,
  input wire SWEEP_AUTO_CLEAR_ALL,
  input wire UPDATE_PIN,
  input wire [3:0] PROFILE_PIN,
  output wire [CHANNELS-1:0] SINE_SELECT,
  output wire [CHANNELS-1:0] PHASE_ACC_CLEAR,
  output reg [CHANNELS-1:0] PHASE_ACC_ZERO,
  output wire [CHANNELS-1:0] SWEEP_ACC_CLEAR,
  output reg [CHANNELS-1:0] SWEEP_ACC_ZERO,
  output wire [CHANNELS-1:0] MATCH_DELAY,
  output wire [CHANNELS-1:0] DAC_POWER_DOWN,
  output wire [CHANNELS-1:0] CORE_POWER_DOWN,
  output wire [2*CHANNELS-1:0] DAC_LSB_CONTROL,
  output wire [CHANNELS-1:0] SWEEP_ENABLE,
  output wire [CHANNELS-1:0] SWEEP_NO_DWELL,
  output wire [3*CHANNELS-1:0] DATA_ALIGN,
  output wire [2*CHANNELS-1:0] MODULATION_TYPE,
  output wire [32*CHANNELS-1:0] FREQUENCY_WORD,
  output wire [14*CHANNELS-1:0] PHASE_OFFSET,
  output wire [10*CHANNELS-1:0] AMPLITUDE_SCALE,
  output wire [2*CHANNELS-1:0] AMPLITUDE_STEP,
  output wire [CHANNELS-1:0] MULTIPLIER_ENABLE,
  output wire [CHANNELS-1:0] AUTO_RAMP,
  output wire [32*CHANNELS-1:0] RISING_DELTA,
  output wire [32*CHANNELS-1:0] FALLING_DELTA,
  output reg [CHANNELS-1:0] SWEEP_TICK,
  output reg [CHANNELS-1:0] AMPLITUDE_TICK
);

  // Update and profile pins come from outside and pass two flip-flops.
  reg update_meta;
  reg update_sync;
  reg update_last;
  reg [3:0] profile_meta;
  reg [3:0] profile_sync;
  reg [3:0] profile_last;
  wire update_event;
  wire profile_change;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      update_meta <= 1'b0;
      update_sync <= 1'b0;
      update_last <= 1'b0;
      profile_meta <= 4'h0;
      profile_sync <= 4'h0;
      profile_last <= 4'h0;
    end else begin
      update_meta <= UPDATE_PIN;
      update_sync <= update_meta;
      update_last <= update_sync;
      profile_meta <= PROFILE_PIN;
      profile_sync <= profile_meta;
      profile_last <= profile_sync;
    end
  end

  // An update is the rising edge of the synchronised pin.
  assign update_event = update_sync & ~update_last;
  assign profile_change = |(profile_sync ^ profile_last);

  // Returns a one-hot write select for the seven channel registers.
  function [6:0] reg_select;
    input [7:0] addr;
    begin
      reg_select = 7'h00;
      case (addr)
        `DCR_ADDR_FUNCTION: reg_select = 7'h01;
        `DCR_ADDR_FREQ: reg_select = 7'h02;
        `DCR_ADDR_PHASE: reg_select = 7'h04;
        `DCR_ADDR_AMP: reg_select = 7'h08;
        `DCR_ADDR_SWEEP_RATE: reg_select = 7'h10;
        `DCR_ADDR_RISE_DELTA: reg_select = 7'h20;
        `DCR_ADDR_FALL_DELTA: reg_select = 7'h40;
        default: reg_select = 7'h00;
      endcase
    end
  endfunction

  wire [6:0] write_sel;
  assign write_sel = WRITE_STROBE ? reg_select(WRITE_ADDR) : 7'h00;

  // Read-back image of every channel's buffered registers.
  wire [32*7*CHANNELS-1:0] read_image;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      reg [23:0] function_buf;
      reg [31:0] freq_buf;
      reg [15:0] phase_buf;
      reg [23:0] amp_buf;
      reg [15:0] rate_buf;
      reg [31:0] rise_buf;
      reg [31:0] fall_buf;
      reg [23:0] function_act;
      reg [31:0] freq_act;
      reg [15:0] phase_act;
      reg [23:0] amp_act;
      reg [15:0] rate_act;
      reg [31:0] rise_act;
      reg [31:0] fall_act;
      reg [15:0] sweep_timer;
      reg [7:0] amp_timer;
      wire take;
      wire [23:0] next_function;
      wire [23:0] next_amp;
      wire sweep_reload;
      wire amp_reload;

      // Only channels whose enable bit is set take a write.
      assign take = CHANNEL_ENABLE[ch]; // R24

      // Writes land in the buffers; active copies follow on update.
      always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          function_buf <= `DCR_FUNCTION_RESET; // R10
          freq_buf <= `DCR_WORD_RESET;
          phase_buf <= `DCR_PHASE_RESET;
          amp_buf <= `DCR_AMP_RESET;
          rate_buf <= `DCR_SWEEP_RATE_RESET;
          rise_buf <= `DCR_WORD_RESET;
          fall_buf <= `DCR_WORD_RESET;
        end else if (take) begin
          if (write_sel[0]) function_buf <= WRITE_DATA[23:0];
          if (write_sel[1]) freq_buf <= WRITE_DATA; // R15
          if (write_sel[2]) phase_buf <= WRITE_DATA[15:0];
          if (write_sel[3]) amp_buf <= WRITE_DATA[23:0]; // R17
          if (write_sel[4]) rate_buf <= WRITE_DATA[15:0]; // R21
          if (write_sel[5]) rise_buf <= WRITE_DATA; // R22
          if (write_sel[6]) fall_buf <= WRITE_DATA; // R23
        end
      end

      // The update event moves every buffer to the active set at once.
      always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          function_act <= `DCR_FUNCTION_RESET;
          freq_act <= `DCR_WORD_RESET;
          phase_act <= `DCR_PHASE_RESET;
          amp_act <= `DCR_AMP_RESET;
          rate_act <= `DCR_SWEEP_RATE_RESET;
          rise_act <= `DCR_WORD_RESET;
          fall_act <= `DCR_WORD_RESET;
        end else if (update_event) begin
          function_act <= function_buf; // R25
          freq_act <= freq_buf;
          phase_act <= phase_buf;
          amp_act <= amp_buf;
          rate_act <= rate_buf;
          rise_act <= rise_buf;
          fall_act <= fall_buf;
        end
      end

      // Settings that the reload decisions see at the update edge.
      assign next_function = update_event ? function_buf : function_act;
      assign next_amp = update_event ? amp_buf : amp_act;

      // Sweep timer reloads at one, or on update when bit 13 asks.
      assign sweep_reload = (sweep_timer <= `DCR_TIMER_END_SWEEP) |
        (update_event & next_function[`DCR_CF_RATE_LOAD]); // R11

      // Amplitude timer reloads at one, or on update or profile change when active bit 10 is set.
      assign amp_reload = (amp_timer <= `DCR_TIMER_END_AMP) |
        (amp_act[`DCR_AC_RATE_LOAD] & (update_event | profile_change)); // R18

      // Ramp-rate timers count down and tick on each timeout.
      always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          sweep_timer <= `DCR_SWEEP_RATE_RESET;
          amp_timer <= 8'h00;
          SWEEP_TICK[ch] <= 1'b0;
          AMPLITUDE_TICK[ch] <= 1'b0;
        end else begin
          if (!function_act[`DCR_CF_SWEEP_EN]) begin
            sweep_timer <= rate_act;
            SWEEP_TICK[ch] <= 1'b0;
          end else if (sweep_reload) begin
            sweep_timer <= update_event ? rate_buf : rate_act;
            SWEEP_TICK[ch] <= sweep_timer <= `DCR_TIMER_END_SWEEP; // R12
          end else begin
            sweep_timer <= sweep_timer - 16'h0001;
            SWEEP_TICK[ch] <= 1'b0;
          end
          if (!(amp_act[`DCR_AC_MULT_EN] & amp_act[`DCR_AC_AUTO])) begin
            amp_timer <= amp_act[`DCR_AC_RATE_HI:`DCR_AC_RATE_LO];
            AMPLITUDE_TICK[ch] <= 1'b0;
          end else if (amp_reload) begin
            amp_timer <= next_amp[`DCR_AC_RATE_HI:`DCR_AC_RATE_LO];
            AMPLITUDE_TICK[ch] <= amp_timer <= `DCR_TIMER_END_AMP;
          end else begin
            amp_timer <= amp_timer - 8'h01;
            AMPLITUDE_TICK[ch] <= 1'b0;
          end
        end
      end

      // One-cycle synchronous zero strobes on the update event.
      always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
          PHASE_ACC_ZERO[ch] <= 1'b0;
          SWEEP_ACC_ZERO[ch] <= 1'b0;
        end else begin
          PHASE_ACC_ZERO[ch] <= update_event &
            next_function[`DCR_CF_PHASE_AUTO]; // R4
          SWEEP_ACC_ZERO[ch] <= update_event &
            (next_function[`DCR_CF_SWEEP_AUTO] | // R6
            SWEEP_AUTO_CLEAR_ALL); // R1
        end
      end

      // Function bits drive the channel datapath directly; no-dwell is also gated by bit 14.
      assign SINE_SELECT[ch] = function_act[`DCR_CF_SINE]; // R2
      assign PHASE_ACC_CLEAR[ch] = function_act[`DCR_CF_PHASE_CLR]; // R3
      assign SWEEP_ACC_CLEAR[ch] = function_act[`DCR_CF_SWEEP_CLR]; // R5
      assign MATCH_DELAY[ch] = function_act[`DCR_CF_MATCH_DELAY]; // R7
      assign DAC_POWER_DOWN[ch] = function_act[`DCR_CF_DAC_PD]; // R8
      assign CORE_POWER_DOWN[ch] = function_act[`DCR_CF_CORE_PD]; // R9
      assign DAC_LSB_CONTROL[2*ch+1:2*ch] =
        function_act[`DCR_CF_LSB_HI:`DCR_CF_LSB_LO];
      assign SWEEP_ENABLE[ch] = function_act[`DCR_CF_SWEEP_EN]; // R12
      assign SWEEP_NO_DWELL[ch] = function_act[`DCR_CF_NO_DWELL] &
        function_act[`DCR_CF_SWEEP_EN]; // R13
      assign DATA_ALIGN[3*ch+2:3*ch] =
        function_act[`DCR_CF_ALIGN_HI:`DCR_CF_ALIGN_LO]; // R14
      assign MODULATION_TYPE[2*ch+1:2*ch] =
        function_act[`DCR_CF_MOD_HI:`DCR_CF_MOD_LO]; // R14

      // Words and amplitude fields for the datapath.
      assign FREQUENCY_WORD[32*ch+31:32*ch] = freq_act; // R15
      assign PHASE_OFFSET[14*ch+13:14*ch] = phase_act[`DCR_PH_HI:0]; // R16
      assign AMPLITUDE_SCALE[10*ch+9:10*ch] =
        amp_act[`DCR_AC_SCALE_HI:0]; // R17
      assign AMPLITUDE_STEP[2*ch+1:2*ch] =
        amp_act[`DCR_AC_STEP_HI:`DCR_AC_STEP_LO]; // R17
      assign MULTIPLIER_ENABLE[ch] = amp_act[`DCR_AC_MULT_EN]; // R20
      assign AUTO_RAMP[ch] = amp_act[`DCR_AC_AUTO] &
        amp_act[`DCR_AC_MULT_EN]; // R19
      assign RISING_DELTA[32*ch+31:32*ch] = rise_act; // R22
      assign FALLING_DELTA[32*ch+31:32*ch] = fall_act; // R23

      // Buffered values as software wrote them, for read-back.
      assign read_image[224*ch+223:224*ch] = {fall_buf, rise_buf,
        16'h0000, rate_buf, 8'h00, amp_buf, 16'h0000, phase_buf,
        freq_buf, 8'h00, function_buf};
    end
  endgenerate

  // Read data returns the addressed buffer of the chosen channel.
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      READ_DATA <= 32'h00000000;
    end else begin
      case (reg_select(READ_ADDR))
        7'h01: READ_DATA <= read_image[224*READ_CHANNEL+:32];
        7'h02: READ_DATA <= read_image[224*READ_CHANNEL+32+:32];
        7'h04: READ_DATA <= read_image[224*READ_CHANNEL+64+:32];
        7'h08: READ_DATA <= read_image[224*READ_CHANNEL+96+:32];
        7'h10: READ_DATA <= read_image[224*READ_CHANNEL+128+:32];
        7'h20: READ_DATA <= read_image[224*READ_CHANNEL+160+:32];
        7'h40: READ_DATA <= read_image[224*READ_CHANNEL+192+:32];
        default: READ_DATA <= 32'h00000000;
      endcase
    end
  end

endmodule // dcr_channel_regs
`default_nettype wire

// ---- dcr_channel_regs_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module dcr_channel_regs_chk #(
  parameter int CHANNELS = 4
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic UPDATE_PIN,
  input wire logic SWEEP_AUTO_CLEAR_ALL,
  input wire logic [CHANNELS-1:0] SINE_SELECT,
  input wire logic [CHANNELS-1:0] PHASE_ACC_CLEAR,
  input wire logic [32*CHANNELS-1:0] FREQUENCY_WORD,
  input wire logic [CHANNELS-1:0] PHASE_ACC_ZERO,
  input wire logic [CHANNELS-1:0] SWEEP_ACC_ZERO,
  input wire logic [CHANNELS-1:0] SWEEP_ENABLE,
  input wire logic [CHANNELS-1:0] SWEEP_NO_DWELL,
  input wire logic [CHANNELS-1:0] MULTIPLIER_ENABLE,
  input wire logic [CHANNELS-1:0] AUTO_RAMP,
  input wire logic [CHANNELS-1:0] SWEEP_TICK,
  input wire logic [CHANNELS-1:0] AMPLITUDE_TICK
);
  // All checks run on the system clock and pause during reset.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // Active values move only in the few cycles after an update.
  a_active_hold_update: assert property (
    !$stable({SINE_SELECT, PHASE_ACC_CLEAR, FREQUENCY_WORD}) |->
    $past(UPDATE_PIN, 2) || $past(UPDATE_PIN, 3) || $past(UPDATE_PIN, 4))
    else $error("active value changed without an update");
  a_phase_zero_pulse: assert property (
    |PHASE_ACC_ZERO |=> ~|PHASE_ACC_ZERO)
    else $error("phase zero strobe longer than one cycle");
  a_sweep_zero_pulse: assert property (
    |SWEEP_ACC_ZERO |=> ~|SWEEP_ACC_ZERO)
    else $error("sweep zero strobe longer than one cycle");
  a_clear_all_sweeps: assert property (
    $rose(UPDATE_PIN) && SWEEP_AUTO_CLEAR_ALL |-> ##[2:5] &SWEEP_ACC_ZERO)
    else $error("global auto clear missed a channel");
  a_no_dwell_gate: assert property (
    SWEEP_NO_DWELL[0] |-> SWEEP_ENABLE[0])
    else $error("no-dwell active while sweep disabled");
  a_auto_ramp_gate: assert property (
    AUTO_RAMP[0] |-> MULTIPLIER_ENABLE[0])
    else $error("auto ramp active with multiplier off");
  a_sweep_tick_gate: assert property (
    SWEEP_TICK[0] |-> $past(SWEEP_ENABLE[0]) || $past(SWEEP_ENABLE[0], 2))
    else $error("sweep tick without sweep enabled");
  a_amp_tick_gate: assert property (
    AMPLITUDE_TICK[0] |-> $past(AUTO_RAMP[0]) || $past(AUTO_RAMP[0], 2))
    else $error("amplitude tick without auto ramp");

  // Main scenarios reached.
  c_clear_all: cover property (&SWEEP_ACC_ZERO);
  c_sweep_tick: cover property (SWEEP_TICK[0]);
  c_amp_tick: cover property (AUTO_RAMP[0] && AMPLITUDE_TICK[0]);
endmodule // dcr_channel_regs_chk
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dcr_defs.vh"
module testbench;
  logic CLOCK, RST, WRITE_STROBE, SWEEP_AUTO_CLEAR_ALL, UPDATE_PIN;
  logic [7:0] WRITE_ADDR, READ_ADDR;
  logic [31:0] WRITE_DATA;
  logic [3:0] CHANNEL_ENABLE, PROFILE_PIN;
  logic [1:0] READ_CHANNEL;
  wire [31:0] READ_DATA;
  wire [3:0] SINE_SELECT, PHASE_ACC_CLEAR, PHASE_ACC_ZERO, SWEEP_ACC_CLEAR;
  wire [3:0] SWEEP_ACC_ZERO, MATCH_DELAY, DAC_POWER_DOWN, CORE_POWER_DOWN;
  wire [3:0] SWEEP_ENABLE, SWEEP_NO_DWELL, MULTIPLIER_ENABLE, AUTO_RAMP;
  wire [3:0] SWEEP_TICK, AMPLITUDE_TICK;
  wire [7:0] DAC_LSB_CONTROL, MODULATION_TYPE, AMPLITUDE_STEP;
  wire [11:0] DATA_ALIGN;
  wire [55:0] PHASE_OFFSET;
  wire [39:0] AMPLITUDE_SCALE;
  wire [127:0] FREQUENCY_WORD, RISING_DELTA, FALLING_DELTA;
  wire [1:0] tk = {AMPLITUDE_TICK[0], SWEEP_TICK[0]};
  int err_total = 0;
  int compares = 0;
  logic [3:0] pz, sz;
  logic [31:0] fx [4] = '{32'h33334444, 32'h11112222, 32'h33334444, 32'h0};

  dcr_channel_regs #(.CHANNELS(4)) dut (
    .CLOCK(CLOCK), .RST(RST), .WRITE_STROBE(WRITE_STROBE),
    .WRITE_ADDR(WRITE_ADDR), .WRITE_DATA(WRITE_DATA),
    .CHANNEL_ENABLE(CHANNEL_ENABLE), .READ_ADDR(READ_ADDR),
    .READ_CHANNEL(READ_CHANNEL), .READ_DATA(READ_DATA),
    .SWEEP_AUTO_CLEAR_ALL(SWEEP_AUTO_CLEAR_ALL), .UPDATE_PIN(UPDATE_PIN),
    .PROFILE_PIN(PROFILE_PIN), .SINE_SELECT(SINE_SELECT),
    .PHASE_ACC_CLEAR(PHASE_ACC_CLEAR), .PHASE_ACC_ZERO(PHASE_ACC_ZERO),
    .SWEEP_ACC_CLEAR(SWEEP_ACC_CLEAR), .SWEEP_ACC_ZERO(SWEEP_ACC_ZERO),
    .MATCH_DELAY(MATCH_DELAY), .DAC_POWER_DOWN(DAC_POWER_DOWN),
    .CORE_POWER_DOWN(CORE_POWER_DOWN), .DAC_LSB_CONTROL(DAC_LSB_CONTROL),
    .SWEEP_ENABLE(SWEEP_ENABLE), .SWEEP_NO_DWELL(SWEEP_NO_DWELL),
    .DATA_ALIGN(DATA_ALIGN), .MODULATION_TYPE(MODULATION_TYPE),
    .FREQUENCY_WORD(FREQUENCY_WORD), .PHASE_OFFSET(PHASE_OFFSET),
    .AMPLITUDE_SCALE(AMPLITUDE_SCALE), .AMPLITUDE_STEP(AMPLITUDE_STEP),
    .MULTIPLIER_ENABLE(MULTIPLIER_ENABLE), .AUTO_RAMP(AUTO_RAMP),
    .RISING_DELTA(RISING_DELTA), .FALLING_DELTA(FALLING_DELTA),
    .SWEEP_TICK(SWEEP_TICK), .AMPLITUDE_TICK(AMPLITUDE_TICK));

  // Compares one value and counts any mismatch.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("Mismatches %0d of %0d comparisons", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One buffered register write to the enabled channels.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] en);
    @(posedge CLOCK);
    WRITE_STROBE <= 1'b1;
    WRITE_ADDR <= a;
    WRITE_DATA <= d;
    CHANNEL_ENABLE <= en;
    @(posedge CLOCK);
    WRITE_STROBE <= 1'b0;
  endtask

  // Read-back of one buffered register, valid one cycle later.
  task automatic rd(input logic [7:0] a, input logic [1:0] ch,
                    output logic [31:0] d);
    @(posedge CLOCK);
    READ_ADDR <= a;
    READ_CHANNEL <= ch;
    @(posedge CLOCK);
    #1 d = READ_DATA;
  endtask

  // Update pulse held three cycles; collects the zero strobes it causes.
  task automatic upd;
    pz = 4'h0;
    sz = 4'h0;
    @(posedge CLOCK);
    UPDATE_PIN <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(posedge CLOCK);
      if (i == 2) UPDATE_PIN <= 1'b0;
      #1 pz = pz | PHASE_ACC_ZERO;
      sz = sz | SWEEP_ACC_ZERO;
    end
  endtask

  // Measures cycles between two ticks of channel 0, with a bound.
  task automatic gap(input int sel, input int exp);
    int n;
    n = 0;
    while (tk[sel] !== 1'b1 && n < 600) begin
      @(posedge CLOCK);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge CLOCK);
      #1 n++;
    end while (tk[sel] !== 1'b1 && n < 600);
    check(n, exp);
    if (n >= 600) complete_run;
  endtask

  // Function register fields of channel 3 against the written pattern.
  task automatic fcheck(input logic [23:0] p);
    check({MODULATION_TYPE[7:6], DATA_ALIGN[11:9], SWEEP_NO_DWELL[3],
      SWEEP_ENABLE[3], DAC_LSB_CONTROL[7:6], CORE_POWER_DOWN[3],
      DAC_POWER_DOWN[3], MATCH_DELAY[3], SWEEP_ACC_CLEAR[3],
      PHASE_ACC_CLEAR[3], SINE_SELECT[3]}, {p[23:22], p[18:16],
      p[15] & p[14], p[14], p[9:8], p[7:5], p[3], p[1:0]});
  endtask

  // Free-running system clock.
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  // Main sequence.
  initial begin
    logic [31:0] d;
    RST = 1'b1;
    WRITE_STROBE = 1'b0;
    WRITE_ADDR = 8'h00;
    WRITE_DATA = 32'h0;
    CHANNEL_ENABLE = 4'hf;
    READ_ADDR = 8'h00;
    READ_CHANNEL = 2'd0;
    SWEEP_AUTO_CLEAR_ALL = 1'b0;
    UPDATE_PIN = 1'b0;
    PROFILE_PIN = 4'h0;
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    for (int a = 2; a <= 10; a++) begin
      rd(a[7:0], 2'd1, d);
      check(d, 32'h0);
    end
    wr(`DCR_ADDR_FREQ, 32'h11112222, 4'b0010);
    wr(`DCR_ADDR_FREQ, 32'h33334444, 4'b0101);
    wr(`DCR_ADDR_FREQ, 32'h55556666, 4'b0000);
    check(FREQUENCY_WORD[63:32], 32'h0);
    upd;
    for (int c = 0; c < 4; c++) begin
      rd(`DCR_ADDR_FREQ, c[1:0], d);
      check(d, fx[c]);
      check(FREQUENCY_WORD[32*c +: 32], fx[c]);
    end
    wr(`DCR_ADDR_PHASE, 32'hffffffff, 4'hf);
    wr(`DCR_ADDR_AMP, 32'h00055bff, 4'hf);
    wr(`DCR_ADDR_SWEEP_RATE, 32'h00000003, 4'hf);
    wr(`DCR_ADDR_RISE_DELTA, 32'h89abcdef, 4'hf);
    wr(`DCR_ADDR_FALL_DELTA, 32'h01234567, 4'hf);
    wr(`DCR_ADDR_FUNCTION, 32'h00818155, 4'hf);
    upd;
    check(PHASE_OFFSET[55:42], 14'h3fff);
    check({AMPLITUDE_SCALE[9:0], AMPLITUDE_STEP[1:0]}, 12'hffd);
    check({MULTIPLIER_ENABLE[0], AUTO_RAMP[0]}, 2'b11);
    check(RISING_DELTA[127:96], 32'h89abcdef);
    check(FALLING_DELTA[31:0], 32'h01234567);
    check({pz, sz}, 8'hff);
    fcheck(24'h818155);
    gap(1, 5);
    wr(`DCR_ADDR_FUNCTION, 32'h0042c2aa, 4'hf);
    upd;
    check({pz, sz}, 8'h00);
    fcheck(24'h42c2aa);
    gap(0, 3);
    // Profile change with reload bit set restarts the amplitude timer.
    wr(`DCR_ADDR_AMP, 32'h00201fff, 4'hf);
    upd;
    gap(1, 32);
    repeat (10) @(posedge CLOCK);
    PROFILE_PIN <= 4'h1;
    d = 32'h0;
    do begin
      @(posedge CLOCK);
      #1 d++;
    end while (tk[1] !== 1'b1 && d < 60);
    check(d, 32'd35);
    wr(`DCR_ADDR_AMP, 32'h000508ff, 4'hf);
    SWEEP_AUTO_CLEAR_ALL <= 1'b1;
    upd;
    check({pz, sz}, 8'h0f);
    check({MULTIPLIER_ENABLE[0], AUTO_RAMP[0]}, 2'b00);
    complete_run;
  end
endmodule // testbench

bind dcr_channel_regs dcr_channel_regs_chk #(.CHANNELS(CHANNELS)) chk (
  .CLOCK(CLOCK), .RST(RST), .UPDATE_PIN(UPDATE_PIN),
  .SWEEP_AUTO_CLEAR_ALL(SWEEP_AUTO_CLEAR_ALL), .SINE_SELECT(SINE_SELECT),
  .PHASE_ACC_CLEAR(PHASE_ACC_CLEAR), .FREQUENCY_WORD(FREQUENCY_WORD),
  .PHASE_ACC_ZERO(PHASE_ACC_ZERO), .SWEEP_ACC_ZERO(SWEEP_ACC_ZERO),
  .SWEEP_ENABLE(SWEEP_ENABLE), .SWEEP_NO_DWELL(SWEEP_NO_DWELL),
  .MULTIPLIER_ENABLE(MULTIPLIER_ENABLE), .AUTO_RAMP(AUTO_RAMP),
  .SWEEP_TICK(SWEEP_TICK), .AMPLITUDE_TICK(AMPLITUDE_TICK));
`default_nettype wire
